/* File: jlp_consts.svh */
// Purpose: timing-free constants of the link parameter block
// Assumes: included by bare name
// Notes: field positions follow the link configuration octets
`ifndef JLP_CONSTS_SVH
`define JLP_CONSTS_SVH
// operating mode codes
`define JLP_MODE_S4 5'h04
`define JLP_MODE_S8 5'h05
`define JLP_MODE_D4 5'h06
`define JLP_MODE_D8 5'h07
`define JLP_MODE_S16 5'h11
`define JLP_MODE_D16 5'h12
// multiframe length limits, as K minus one
`define JLP_KM1_MIN 5'h11
`define JLP_KM1_MAX 5'h1F
// fixed link format values shared by all modes
`define JLP_N 5'h08
`define JLP_NP 5'h08
`define JLP_F 8'h01
`define JLP_M 8'h01
`define JLP_LINKS 2'h2
`define JLP_DEC 2'h1
// fixed alignment sequence fields
`define JLP_ADJCNT 4'h0
`define JLP_ADJDIR 1'h0
`define JLP_BID 4'h0
`define JLP_CF 5'h00
`define JLP_CS 2'h0
`define JLP_HD 1'h0
`define JLP_JESDV 3'h1
`define JLP_SUBV 3'h1
`define JLP_RES 8'h00
// configuration octet last index
`define JLP_OCT_LAST 4'hD
// reset values
`define JLP_RST_MODE 5'h00
`define JLP_RST_KM1 5'h1F
`define JLP_RST_DID 8'h00
`endif

/* File: jlp_link_cfg.sv */
// Purpose: derive link format and stream the lane alignment parameters
// Assumes: one clock; software inputs are on the same clock
// Notes: FIFO depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
`include "jlp_consts.svh"

// small FIFO with registered output stage
module jlp_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    input wire logic i_clk, // device clock
    input wire logic i_rst, // async reset
    input wire logic i_valid, // write request
    input wire logic [W-1:0] i_data, // write data
    output logic o_ready, // room for a word
    output logic o_valid, // read data valid
    output logic [W-1:0] o_data, // read data
    input wire logic i_ready // reader takes word
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic ov;
        logic [W-1:0] od;
    } jlp_fifo_st_t;
    jlp_fifo_st_t q_ff, nxt_q;
    logic push;
    logic pop;

    assign o_ready = (q_ff.cnt != CW'(D));
    assign o_valid = q_ff.ov;
    assign o_data = q_ff.od;

    // push into memory, refill output stage when it empties
    always_comb
    begin
        nxt_q = q_ff;
        push = i_valid && o_ready;
        pop = (q_ff.cnt != '0) && (!q_ff.ov || i_ready);
        if (q_ff.ov && i_ready)
        begin
            nxt_q.ov = 1'b0;
        end
        if (pop)
        begin
            nxt_q.od = q_ff.mem[q_ff.rp];
            nxt_q.ov = 1'b1;
            nxt_q.rp = q_ff.rp + 1'b1;
        end
        if (push)
        begin
            nxt_q.mem[q_ff.wp] = i_data;
            nxt_q.wp = q_ff.wp + 1'b1;
        end
        nxt_q.cnt = q_ff.cnt + CW'(push) - CW'(pop);
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            q_ff <= '0;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end
endmodule

module jlp_link_cfg import jlp_pkg::*; #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic i_clk, // device clock
    input wire logic i_rst, // async reset, high
    input wire logic [4:0] i_operating_mode_select, // mode code
    input wire logic [4:0] i_frames_per_multiframe_minus_one, // K minus one
    input wire logic [7:0] i_did, // identifier setting
    input wire logic i_scr_en, // scrambler enable
    input wire logic i_cfg_apply, // pulse: take settings
    input wire logic i_frame_tick, // pulse: one frame period
    input wire logic i_ilas_start, // pulse: emit parameters
    input wire logic i_ilas_ready, // consumer takes octet
    output logic o_cfg_ok, // mode and K legal
    output logic o_mode_err, // reserved mode taken
    output logic o_k_err, // illegal K taken
    output logic o_interleave, // single-channel flag
    output logic [3:0] o_lanes, // lanes per link
    output logic [3:0] o_spf, // samples per frame
    output logic [5:0] o_r_x4, // R times four
    output logic o_pll_bypass, // serializer PLL bypassed
    output logic [7:0] o_lane_pd_a, // link A lanes off
    output logic [7:0] o_lane_pd_b, // link B lanes off
    output logic o_scr_en, // scrambler running
    output logic [4:0] o_km1, // applied K minus one
    output logic o_lmfc_pulse, // pulse: multiframe start
    output logic o_ilas_busy, // parameter stream active
    output logic o_ilas_valid, // octet valid
    output logic [15:0] o_ilas_data // link, lane, index, octet
);
    localparam logic [5:0] BYPASS_R_X4 = 6'h00; // R value that skips the PLL
    typedef struct packed {
        logic [4:0] mode;
        logic [4:0] km1;
        logic [7:0] did;
        logic scr;
        jlp_mode_t md;
        logic ok;
        logic mode_err;
        logic k_err;
        logic [7:0] pd_a;
        logic [7:0] pd_b;
        logic [4:0] fcnt;
        logic lmfc;
        jlp_state_t st;
        logic link;
        logic [2:0] lid;
        logic [3:0] oct;
        logic byp;
        logic busy;
    } jlp_st_t;
    jlp_st_t q_ff, nxt_q;
    jlp_mode_t dec;
    logic fifo_ready;
    logic push;
    logic [7:0] did_eff;
    logic [7:0] chk;
    logic [7:0] octet;
    logic k_legal;

    jlp_fifo #(.W(16), .D(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_valid(push),
        .i_data({q_ff.link, q_ff.lid, q_ff.oct, octet}), // whole octet, msb in bit 7, no tail bits
        .o_ready(fifo_ready),
        .o_valid(o_ilas_valid),
        .o_data(o_ilas_data),
        .i_ready(i_ilas_ready)
    );

    // table lookup and K legality of the incoming settings
    assign dec = jlp_decode(i_operating_mode_select);
    assign k_legal = i_frames_per_multiframe_minus_one[0]
        && (i_frames_per_multiframe_minus_one >= `JLP_KM1_MIN);

    // identifier of the link being sent
    assign did_eff = q_ff.did + {7'h00, q_ff.link};

    // checksum over every field of this lane
    assign chk = did_eff + 8'(`JLP_ADJCNT) + 8'(`JLP_BID) + 8'(`JLP_ADJDIR)
        + {5'h00, q_ff.lid} + {7'h00, q_ff.scr} + {4'h0, q_ff.md.lanes} - 8'h01
        + `JLP_F - 8'h01 + {3'h0, q_ff.km1} + `JLP_M - 8'h01 + 8'(`JLP_CS)
        + 8'(`JLP_N) - 8'h01 + 8'(`JLP_SUBV) + 8'(`JLP_NP) - 8'h01
        + 8'(`JLP_JESDV) + {4'h0, q_ff.md.spf} - 8'h01 + 8'(`JLP_HD)
        + 8'(`JLP_CF) + `JLP_RES + `JLP_RES;

    // configuration octet for the current index
    always_comb
    begin
        case (q_ff.oct)
            4'h0: octet = did_eff;
            4'h1: octet = {`JLP_ADJCNT, `JLP_BID};
            4'h2: octet = {1'b0, `JLP_ADJDIR, 1'b0, 2'b00, q_ff.lid};
            4'h3: octet = {q_ff.scr, 2'b00, 5'(q_ff.md.lanes - 4'h1)};
            4'h4: octet = `JLP_F - 8'h01;
            4'h5: octet = {3'h0, q_ff.km1};
            4'h6: octet = `JLP_M - 8'h01;
            4'h7: octet = {`JLP_CS, 1'b0, 5'(`JLP_N - 5'h01)};
            4'h8: octet = {`JLP_SUBV, 5'(`JLP_NP - 5'h01)};
            4'h9: octet = {`JLP_JESDV, 5'(q_ff.md.spf - 4'h1)};
            4'hA: octet = {`JLP_HD, 2'b00, `JLP_CF};
            4'hB: octet = `JLP_RES;
            4'hC: octet = `JLP_RES;
            4'hD: octet = chk;
            default: octet = 8'h00;
        endcase
    end

    // settings capture, multiframe counter and parameter sequencer
    always_comb
    begin
        nxt_q = q_ff;
        push = (q_ff.st == JLP_SEND) && fifo_ready;
        nxt_q.lmfc = 1'b0;
        if (i_cfg_apply && (q_ff.st == JLP_IDLE))
        begin
            nxt_q.mode = i_operating_mode_select;
            nxt_q.km1 = i_frames_per_multiframe_minus_one;
            nxt_q.did = i_did;
            nxt_q.scr = i_scr_en;
            nxt_q.md = dec;
            nxt_q.mode_err = !dec.valid;
            nxt_q.k_err = !k_legal;
            nxt_q.ok = dec.valid && k_legal;
            nxt_q.byp = dec.valid && (dec.r_x4 == BYPASS_R_X4);
            nxt_q.pd_a = ~8'((9'h001 << dec.lanes) - 9'h001);
            nxt_q.pd_b = ~8'((9'h001 << dec.lanes) - 9'h001);
            nxt_q.fcnt = 5'h00;
        end
        else if (i_frame_tick)
        begin
            // frame count wraps at the stored K minus one
            if (q_ff.fcnt >= q_ff.km1)
            begin
                nxt_q.fcnt = 5'h00;
                nxt_q.lmfc = 1'b1;
            end
            else
            begin
                nxt_q.fcnt = q_ff.fcnt + 5'h01;
            end
        end
        case (q_ff.st)
            JLP_IDLE:
            begin
                if (i_ilas_start && q_ff.ok)
                begin
                    nxt_q.st = JLP_SEND;
                    nxt_q.link = 1'b0;
                    nxt_q.lid = 3'h0;
                    nxt_q.oct = 4'h0;
                end
            end
            JLP_SEND:
            begin
                // index walks octets, then lanes, then links
                if (push)
                begin
                    nxt_q.oct = q_ff.oct + 4'h1;
                    if (q_ff.oct == `JLP_OCT_LAST)
                    begin
                        nxt_q.oct = 4'h0;
                        nxt_q.lid = q_ff.lid + 3'h1;
                        if ({1'b0, q_ff.lid} == q_ff.md.lanes - 4'h1)
                        begin
                            nxt_q.lid = 3'h0;
                            nxt_q.link = 1'b1;
                            if (q_ff.link)
                            begin
                                nxt_q.link = 1'b0;
                                nxt_q.st = JLP_IDLE;
                            end
                        end
                    end
                end
            end
            default: nxt_q.st = JLP_IDLE;
        endcase
        // busy flag registered so the output needs no decode
        nxt_q.busy = (nxt_q.st == JLP_SEND);
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            q_ff <= '0;
            q_ff.mode <= `JLP_RST_MODE;
            q_ff.km1 <= `JLP_RST_KM1;
            q_ff.did <= `JLP_RST_DID;
            q_ff.pd_a <= 8'hFF;
            q_ff.pd_b <= 8'hFF;
            q_ff.st <= JLP_IDLE;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    // outputs straight from the state register
    assign o_cfg_ok = q_ff.ok;
    assign o_mode_err = q_ff.mode_err;
    assign o_k_err = q_ff.k_err;
    assign o_interleave = q_ff.md.des;
    assign o_lanes = q_ff.md.lanes;
    assign o_spf = q_ff.md.spf;
    assign o_r_x4 = q_ff.md.r_x4;
    assign o_pll_bypass = q_ff.byp;
    assign o_lane_pd_a = q_ff.pd_a;
    assign o_lane_pd_b = q_ff.pd_b;
    assign o_scr_en = q_ff.scr;
    assign o_km1 = q_ff.km1;
    assign o_lmfc_pulse = q_ff.lmfc;
    assign o_ilas_busy = q_ff.busy;
endmodule
`default_nettype wire

/* File: jlp_link_cfg_monitor.sv */
// Purpose: port checker of the link parameter block
// Assumes: one clock, reset high
// Notes: bound in the bench
`timescale 1ns/1ps
`default_nettype none
module jlp_link_cfg_monitor (
    input wire logic i_clk, // clock
    input wire logic i_rst, // reset
    input wire logic [4:0] i_operating_mode_select, // mode
    input wire logic [4:0] i_frames_per_multiframe_minus_one, // K-1
    input wire logic [7:0] i_did, // id
    input wire logic i_scr_en, // scramble
    input wire logic i_cfg_apply, // apply
    input wire logic i_ilas_ready, // taken
    input wire logic o_cfg_ok, // ok
    input wire logic o_mode_err, // bad mode
    input wire logic o_k_err, // bad K
    input wire logic o_interleave, // single
    input wire logic [3:0] o_lanes, // lanes
    input wire logic [3:0] o_spf, // samples
    input wire logic [5:0] o_r_x4, // rate
    input wire logic o_pll_bypass, // bypass
    input wire logic [7:0] o_lane_pd_a, // off A
    input wire logic [7:0] o_lane_pd_b, // off B
    input wire logic o_scr_en, // scramble
    input wire logic [4:0] o_km1, // K-1
    input wire logic o_lmfc_pulse, // wrap
    input wire logic o_ilas_busy, // busy
    input wire logic o_ilas_valid, // valid
    input wire logic [15:0] o_ilas_data // octet
);
    // accepted apply and current octet index
    wire logic acc = i_cfg_apply && !o_ilas_busy;
    wire logic [3:0] ix = o_ilas_data[11:8];
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    a_interleave_flag: assert property (acc |=>
        o_interleave == ($past(i_operating_mode_select) inside {5'h04, 5'h05, 5'h11}))
        else $error("interleave flag wrong");
    a_mode_check: assert property (acc |=>
        o_mode_err == !($past(i_operating_mode_select) inside {5'h04, 5'h05, 5'h06, 5'h07, 5'h11, 5'h12}))
        else $error("mode error flag wrong");
    a_k_check: assert property (acc |=> o_k_err == !($past(i_frames_per_multiframe_minus_one) >= 5'h11 &&
        $past(i_frames_per_multiframe_minus_one[0])))
        else $error("K error flag wrong");
    a_km1_stored: assert property (acc |=> o_km1 == $past(i_frames_per_multiframe_minus_one) &&
        o_scr_en == $past(i_scr_en))
        else $error("applied K or scramble wrong");
    a_lane_power: assert property (o_cfg_ok |-> o_lane_pd_a == (8'hFF << o_lanes) && o_lane_pd_b == o_lane_pd_a)
        else $error("lane power down wrong");
    a_rate_lanes: assert property (o_cfg_ok |-> o_r_x4 * o_lanes == 10'd40 && o_spf == o_lanes && !o_pll_bypass)
        else $error("rate or lane count wrong");
    a_fixed_zero: assert property (o_ilas_valid && ix inside {1, 4, 6, 10, 11, 12} |-> o_ilas_data[7:0] == 8'h00)
        else $error("fixed octet not zero");
    a_sample_bits: assert property (o_ilas_valid && ix inside {7, 8} |->
        o_ilas_data[7:0] == (ix == 4'h8 ? 8'h27 : 8'h07))
        else $error("sample bit octet wrong");
    a_did_link: assert property (o_ilas_valid && ix == 4'h0 |-> o_ilas_data[7:0] == i_did + {7'h00, o_ilas_data[15]})
        else $error("device id octet wrong");
    a_octet_hold: assert property (o_ilas_valid && !i_ilas_ready |=> o_ilas_valid && $stable(o_ilas_data))
        else $error("octet dropped while stalled");
    a_lmfc_single: assert property (o_lmfc_pulse |=> !o_lmfc_pulse)
        else $error("multiframe pulse too long");
endmodule
`default_nettype wire

/* File: jlp_link_cfg_tb.sv */
// Purpose: self-checking bench of the link parameter block
// Assumes: inputs change on the falling edge
// Notes: expected octets rebuilt from the mode table
`timescale 1ns/1ps
`default_nettype none
module jlp_link_cfg_tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [4:0] i_operating_mode_select = 5'h00;
    logic [4:0] i_frames_per_multiframe_minus_one = 5'h1F;
    logic [7:0] i_did = 8'h00;
    logic i_scr_en = 1'b0;
    logic i_cfg_apply = 1'b0;
    logic i_frame_tick = 1'b0;
    logic i_ilas_start = 1'b0;
    logic stall = 1'b0;
    logic i_ilas_ready, o_cfg_ok, o_mode_err, o_k_err, o_interleave, o_pll_bypass, o_scr_en;
    logic o_lmfc_pulse, o_ilas_busy, o_ilas_valid;
    logic [3:0] o_lanes, o_spf;
    logic [5:0] o_r_x4;
    logic [7:0] o_lane_pd_a, o_lane_pd_b;
    logic [4:0] o_km1;
    logic [15:0] o_ilas_data;
    logic [4:0] mt [6] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h11, 5'h12};
    int lt [6] = '{2, 4, 2, 4, 8, 8};
    int n_fail = 0;
    int num_checks = 0;
    // free-running device clock
    always #20 i_clk = ~i_clk;
    jlp_link_cfg u_dut (.i_clk, .i_rst, .i_operating_mode_select, .i_frames_per_multiframe_minus_one, .i_did,
        .i_scr_en, .i_cfg_apply, .i_frame_tick, .i_ilas_start, .i_ilas_ready, .o_cfg_ok, .o_mode_err, .o_k_err,
        .o_interleave, .o_lanes, .o_spf, .o_r_x4, .o_pll_bypass, .o_lane_pd_a, .o_lane_pd_b, .o_scr_en, .o_km1,
        .o_lmfc_pulse, .o_ilas_busy, .o_ilas_valid, .o_ilas_data);
    jlp_rx_model u_rx (.i_clk, .i_rst, .i_stall(stall), .o_ready(i_ilas_ready));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic set_cfg(input logic [4:0] m, input logic [4:0] k);
        @(negedge i_clk);
        i_operating_mode_select = m;
        i_frames_per_multiframe_minus_one = k;
        i_cfg_apply = 1'b1;
        @(negedge i_clk);
        i_cfg_apply = 1'b0;
    endtask
    // start a stream, try a reserved apply while busy, check every octet
    task automatic run_ilas(input logic [4:0] m, input int l);
        logic [7:0] ex [14];
        int guard;
        @(negedge i_clk);
        i_ilas_start = 1'b1;
        @(negedge i_clk);
        i_ilas_start = 1'b0;
        i_operating_mode_select = 5'h08;
        i_cfg_apply = 1'b1;
        @(negedge i_clk);
        i_cfg_apply = 1'b0;
        i_operating_mode_select = m;
        for (int ln = 0; ln < 2; ln++)
            for (int la = 0; la < l; la++)
            begin
                ex = '{i_did + 8'(ln), 8'h00, 8'(la), {i_scr_en, 7'(l - 1)}, 8'h00, 8'(i_frames_per_multiframe_minus_one),
                    8'h00, 8'h07, 8'h27, 8'(32 + l - 1), 8'h00, 8'h00, 8'h00, 8'h00};
                ex[13] = ex[0] + 8'(la) + 8'(i_scr_en) + 8'(l - 1) + ex[5] + 8'd16 + 8'(l - 1);
                for (int k = 0; k < 14; k++)
                begin
                    guard = 0;
                    do
                    begin
                        @(negedge i_clk);
                        guard++;
                    end
                    while (!(o_ilas_valid === 1'b1 && i_ilas_ready === 1'b1) && guard < 300);
                    if (guard >= 300)
                    begin
                        n_fail++;
                        final_report();
                    end
                    chk(o_ilas_data, {1'(ln), 3'(la), 4'(k), ex[k]});
                    // let the offered octet be taken
                    @(posedge i_clk);
                end
            end
        @(negedge i_clk);
        chk({14'h0, o_ilas_busy, o_mode_err}, 16'h0000);
    endtask
    // main sequence
    initial
    begin
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        chk({3'h0, o_km1, o_lane_pd_a}, 16'h1FFF);
        $display("test reset done");
        set_cfg(5'h08, 5'h10);
        chk({13'h0, o_cfg_ok, o_mode_err, o_k_err}, 16'h0003);
        @(negedge i_clk);
        i_ilas_start = 1'b1;
        @(negedge i_clk);
        i_ilas_start = 1'b0;
        @(negedge i_clk);
        chk({15'h0, o_ilas_busy}, 16'h0000);
        $display("test reserved done");
        for (int i = 0; i < 6; i++)
        begin
            i_did = 8'hFA + 8'(i);
            i_scr_en = 1'(i);
            stall = (i > 3);
            set_cfg(mt[i], 5'(17 + 2 * i));
            chk({10'h0, o_cfg_ok, o_interleave, o_lanes},
                {10'h0, 1'b1, 1'(i == 0 || i == 1 || i == 4), 4'(lt[i])});
            chk({10'h0, o_r_x4}, 16'(40 / lt[i]));
            chk({7'h0, o_scr_en, o_lane_pd_b}, {7'h0, i_scr_en, 8'hFF << lt[i]});
            run_ilas(mt[i], lt[i]);
            $display("test mode %0d done", mt[i]);
        end
        set_cfg(5'h04, 5'h11);
        @(negedge i_clk);
        i_frame_tick = 1'b1;
        repeat (17) @(negedge i_clk);
        chk({15'h0, o_lmfc_pulse}, 16'h0000);
        @(negedge i_clk);
        i_frame_tick = 1'b0;
        chk({15'h0, o_lmfc_pulse}, 16'h0001);
        @(negedge i_clk);
        chk({15'h0, o_lmfc_pulse}, 16'h0000);
        $display("test multiframe done");
        final_report();
    end
endmodule
bind jlp_link_cfg jlp_link_cfg_monitor u_mon (.i_clk, .i_rst, .i_operating_mode_select,
    .i_frames_per_multiframe_minus_one, .i_did, .i_scr_en, .i_cfg_apply, .i_ilas_ready, .o_cfg_ok, .o_mode_err,
    .o_k_err, .o_interleave, .o_lanes, .o_spf, .o_r_x4, .o_pll_bypass, .o_lane_pd_a, .o_lane_pd_b, .o_scr_en,
    .o_km1, .o_lmfc_pulse, .o_ilas_busy, .o_ilas_valid, .o_ilas_data);
`default_nettype wire

/* File: jlp_pkg.sv */
// Purpose: types and mode table of the link parameter block
// Assumes: constants come from jlp_consts.svh
// Notes: reserved mode codes decode as not valid
`include "jlp_consts.svh"
package jlp_pkg;
    typedef enum logic {JLP_IDLE, JLP_SEND} jlp_state_t;
    typedef struct packed {
        logic valid;
        logic des;
        logic [3:0] lanes;
        logic [3:0] spf;
        logic [5:0] r_x4;
    } jlp_mode_t;
    // mode table: single or dual, lanes per link, samples per frame, R times four
    function automatic jlp_mode_t jlp_decode(input logic [4:0] mode);
        jlp_mode_t d;
        d = '{valid: 1'b1, des: 1'b1, lanes: 4'h2, spf: 4'h2, r_x4: 6'h14};
        case (mode)
            `JLP_MODE_S4: d.des = 1'b1;
            `JLP_MODE_D4: d.des = 1'b0;
            `JLP_MODE_S8, `JLP_MODE_D8:
            begin
                d.des = (mode == `JLP_MODE_S8);
                d.lanes = 4'h4;
                d.spf = 4'h4;
                d.r_x4 = 6'h0A;
            end
            `JLP_MODE_S16, `JLP_MODE_D16:
            begin
                d.des = (mode == `JLP_MODE_S16);
                d.lanes = 4'h8;
                d.spf = 4'h8;
                d.r_x4 = 6'h05;
            end
            default: d = '0;
        endcase
        return d;
    endfunction
endpackage

/* File: jlp_rx_model.sv */
// Purpose: receiver side that takes alignment octets
// Assumes: octets offered with valid and held until taken
// Notes: stall mode takes one octet in two so the FIFO fills
`timescale 1ns/1ps
`default_nettype none
module jlp_rx_model (
    input wire logic i_clk, // device clock
    input wire logic i_rst, // async reset
    input wire logic i_stall, // slow pattern on
    output logic o_ready // takes octet
);
    logic [1:0] cnt_ff;
    // ready low half the time while stalling
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_ff <= 2'h0;
            o_ready <= 1'b0;
        end
        else
        begin
            cnt_ff <= cnt_ff + 2'h1;
            o_ready <= !i_stall || cnt_ff[1];
        end
    end
endmodule
`default_nettype wire
